//--- inc/sram_timing_cfg.svh
// constants for the static memory timing readback block
// Notes on behaviour
// - turnaround time reads at bits 19:17, codes 1..7 clocks
// - page cycle time reads at bits 16:14, codes 1..7 clocks
// - write pulse width reads at bits 13:11, codes 1..7 clocks
// - chip-select to output-enable delay reads at bits 10:8, codes 1..7
// - write cycle length reads at bits 7:4, codes 3..15 clocks
// - read cycle length reads at bits 3:0, codes 2..15 clocks
// - four independent readback copies, one per chip select 0..3
// - all counts are memory clocks, half the system clock rate
// - update command copies staged timing into the readback register of the chip select it names
// - multiplexed bus mode widens the effective write pulse of the last updated chip select by one clock, wrapping to 0 at code 7
// - page access and page cycle apply only in separate bus mode
`ifndef SRAM_TIMING_CFG_SVH
`define SRAM_TIMING_CFG_SVH
`define ADDR_W 4
`define OFS_READBACK0 4'h0
`define OFS_READBACK1 4'h1
`define OFS_READBACK2 4'h2
`define OFS_READBACK3 4'h3
`define OFS_STAGE 4'h4
`define OFS_CMD 4'h5
`define OFS_MODE 4'h6
`define CMD_UPDATE_BIT 0
`define CMD_CS_LSB 1
`define MODE_MUX_BIT 0
`define TIMING_RESET 20'h2B3CC
`define TIMING_MASK 32'h000FFFFF
`endif

//--- inc/sram_timing_pkg.sv
// types for the static memory timing readback block
package sram_timing_pkg;
  typedef struct packed {
    logic [2:0] turnaround_clocks;
    logic [2:0] page_cycle_clocks;
    logic [2:0] write_pulse_clocks;
    logic [2:0] cs_to_oe_clocks;
    logic [3:0] write_cycle_clocks;
    logic [3:0] read_cycle_clocks;
  } timing_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic [0:0] {
    MEM_PHASE_LOW = 1'b0,
    MEM_PHASE_HIGH = 1'b1
  } mem_phase_t;
endpackage

//--- hw/timing_slot.sv
// one chip select's timing readback register
`timescale 1ns/1ps
`include "sram_timing_cfg.svh"
module timing_slot (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // load from staging
  input wire logic load_i,
  input wire sram_timing_pkg::timing_t staged_i,
  // readback
  output sram_timing_pkg::timing_t timing_o
);
  import sram_timing_pkg::*;
  timing_t timing_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timing_reg <= timing_t'(`TIMING_RESET);
    end else if (load_i) begin
      timing_reg <= staged_i;
    end
  end
  assign timing_o = timing_reg;
  a_slot_load: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    load_i |=> timing_o == $past(staged_i)) else $error("slot did not load");
  a_slot_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !load_i |=> $stable(timing_o)) else $error("slot changed without load");
endmodule

//--- hw/sram_timing_readback.sv
// timing readback registers with staging, update command and memory clock
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "sram_timing_cfg.svh"
module sram_timing_readback (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // memory-side timing
  output logic mem_clk_en_o,
  output logic mux_mode_o,
  output logic [2:0] write_pulse_eff_o,
  output logic page_enable_o,
  output sram_timing_pkg::timing_t cs_timing_o [4]
);
  import sram_timing_pkg::*;
  ////////////////////////////////////////////////////////////////
  timing_t staged_reg;
  logic mux_reg;
  logic [1:0] sel_reg;
  logic [31:0] rdata_reg;
  mem_phase_t phase_reg;
  timing_t slot_q [4];
  logic [3:0] load_w;
  wire hit_stage = wr_i && (addr_i == `OFS_STAGE);
  wire hit_cmd = wr_i && (addr_i == `OFS_CMD);
  wire hit_mode = wr_i && (addr_i == `OFS_MODE);
  wire do_update = hit_cmd && wdata_i[`CMD_UPDATE_BIT];
  wire [1:0] cmd_cs = wdata_i[`CMD_CS_LSB +: 2];
  ////////////////////////////////////////////////////////////////
  // four independent copies; readback offsets take no writes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      assign load_w[gi] = do_update && (cmd_cs == 2'(gi));
      timing_slot u_slot (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .load_i(load_w[gi]),
        .staged_i(staged_reg),
        .timing_o(slot_q[gi])
      );
      assign cs_timing_o[gi] = slot_q[gi];
    end
  endgenerate
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      staged_reg <= timing_t'(`TIMING_RESET);
      mux_reg <= 1'b0;
      sel_reg <= 2'h0;
    end else begin
      if (hit_stage) staged_reg <= timing_t'(wdata_i[19:0]);
      if (hit_mode) mux_reg <= wdata_i[`MODE_MUX_BIT];
      if (do_update) sel_reg <= cmd_cs;
    end
  end
  // memory clock enable at half the system rate
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) phase_reg <= MEM_PHASE_LOW;
    else phase_reg <= (phase_reg == MEM_PHASE_LOW) ? MEM_PHASE_HIGH : MEM_PHASE_LOW;
  end
  assign mem_clk_en_o = (phase_reg == MEM_PHASE_HIGH);
  ////////////////////////////////////////////////////////////////
  // effective timing of the last updated chip select
  wire timing_t cur = slot_q[sel_reg];
  assign mux_mode_o = mux_reg;
  // extra clock wraps to 0 if the code is 7; field width kept
  assign write_pulse_eff_o = mux_reg ? 3'(cur.write_pulse_clocks + 3'h1)
                                     : cur.write_pulse_clocks;
  assign page_enable_o = !mux_reg;
  ////////////////////////////////////////////////////////////////
  // read mux: fields land at bits 19:0, upper bits zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr_i)
      `OFS_READBACK0: rd_mux = {12'h000, slot_q[0]};
      `OFS_READBACK1: rd_mux = {12'h000, slot_q[1]};
      `OFS_READBACK2: rd_mux = {12'h000, slot_q[2]};
      `OFS_READBACK3: rd_mux = {12'h000, slot_q[3]};
      `OFS_MODE: rd_mux = {31'h00000000, mux_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_reg <= 32'h00000000;
    else rdata_reg <= rd_i ? rd_mux : 32'h00000000;
  end
  assign rdata_o = rdata_reg;
  ////////////////////////////////////////////////////////////////
  sequence s_update(int k);
    do_update && cmd_cs == 2'(k);
  endsequence
  a_update_cs0: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_update(0) |=> slot_q[0] == $past(staged_reg)) else $error("cs0 not updated");
  a_cs_independent: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_update(1) |=> $stable(slot_q[0]) && $stable(slot_q[2])) else $error("other cs moved");
  a_read_fields: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    rd_i && addr_i == `OFS_READBACK2 |=> rdata_o == {12'h000, $past(slot_q[2])})
    else $error("readback mismatch");
  a_read_upper_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    rd_i |=> rdata_o[31:20] == 12'h000) else $error("upper bits not zero");
  a_readback_nowrite: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr_i && addr_i == `OFS_READBACK3 && !do_update |=> $stable(slot_q[3]))
    else $error("readback took a write");
  a_mem_clk_half: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mem_clk_en_o |=> !mem_clk_en_o ##1 mem_clk_en_o) else $error("memory clock not half");
  a_mux_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mux_mode_o |-> write_pulse_eff_o == 3'(cur.write_pulse_clocks + 3'h1))
    else $error("mux pulse not widened");
  a_page_sep_only: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    page_enable_o != mux_mode_o) else $error("page enabled in mux mode");
  ////////////////////////////////////////////////////////////////
  // per chip select: only its own update moves it, readback shows only it

  generate
    for (gi = 0; gi < 4; gi++) begin : g_chk
      a_update_slot: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        do_update && cmd_cs == 2'(gi) |=> slot_q[gi] == $past(staged_reg))
        else $error("slot not updated");

      a_update_other: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        do_update && cmd_cs != 2'(gi) |=> $stable(slot_q[gi]))
        else $error("slot moved on foreign update");

      a_nocmd_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !do_update |=> $stable(slot_q[gi]))
        else $error("slot moved without update");

      a_read_slot: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        rd_i && addr_i == 4'(gi) |=> rdata_o == {12'h000, $past(slot_q[gi])})
        else $error("slot readback mismatch");

      a_out_slot: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        cs_timing_o[gi] == slot_q[gi]) else $error("timing out differs");
    end
  endgenerate
  ////////////////////////////////////////////////////////////////
  // staging, mode and selection registers follow only their own writes
  a_stage_take: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hit_stage |=> staged_reg == timing_t'($past(wdata_i[19:0])))
    else $error("staging not taken");

  a_stage_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !hit_stage |=> $stable(staged_reg))
    else $error("staging moved");

  a_stage_cmd_apart: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hit_cmd |=> $stable(staged_reg))
    else $error("command touched staging");

  a_mode_take: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hit_mode |=> mux_mode_o == $past(wdata_i[`MODE_MUX_BIT]))
    else $error("mode not taken");

  a_mode_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !hit_mode |=> $stable(mux_mode_o))
    else $error("mode moved");

  a_stage_mode_apart: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hit_stage |=> $stable(mux_mode_o))
    else $error("staging touched mode");

  a_sel_take: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    do_update |=> sel_reg == $past(cmd_cs))
    else $error("selection not taken");

  a_sel_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !do_update |=> $stable(sel_reg))
    else $error("selection moved");

  ////////////////////////////////////////////////////////////////
  // bus mode effects on the memory side
  a_sep_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !mux_mode_o |-> write_pulse_eff_o == cur.write_pulse_clocks)
    else $error("pulse widened in separate mode");

  a_page_mux_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mux_mode_o |-> !page_enable_o)
    else $error("page access in mux mode");

  a_page_sep_on: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !mux_mode_o |-> page_enable_o)
    else $error("page access off in separate mode");

  a_mem_clk_low: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !mem_clk_en_o |=> mem_clk_en_o)
    else $error("memory clock stalled");

  ////////////////////////////////////////////////////////////////
  // read port: data stand one cycle, unmapped and write-only read zero
  sequence s_read_at(logic [3:0] a);
    rd_i && addr_i == a;
  endsequence

  a_read_idle: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !rd_i |=> rdata_o == 32'h00000000)
    else $error("read data outside read");

  a_read_mode: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_read_at(`OFS_MODE) |=> rdata_o == {31'h00000000, $past(mux_mode_o)})
    else $error("mode readback mismatch");

  a_read_stage: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_read_at(`OFS_STAGE) |=> rdata_o == 32'h00000000)
    else $error("staging readable");

  a_read_cmd: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_read_at(`OFS_CMD) |=> rdata_o == 32'h00000000)
    else $error("command readable");

  a_read_high: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    rd_i && addr_i > `OFS_MODE |=> rdata_o == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

//--- dv/sram_far_model.sv
// far-side memory model that counts the memory clock phases it is given
`timescale 1ns/1ps
module sram_far_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // memory clock phase from the controller
  input wire logic mem_clk_en_i,
  output logic [7:0] mem_ticks_o
);
  // the memory only acts on enabled phases, so it runs at half the system rate
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) mem_ticks_o <= 8'h00;
    else if (mem_clk_en_i) mem_ticks_o <= mem_ticks_o + 8'h01;
  end
endmodule

//--- dv/sram_timing_readback_test.sv
// self-checking bench for the timing readback block
`timescale 1ns/1ps
module sram_timing_readback_test;
  import sram_timing_pkg::*;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic mem_clk_en_o, mux_mode_o, page_enable_o;
  logic [2:0] write_pulse_eff_o;
  timing_t cs_timing_o [4];
  logic [7:0] ticks, t0;
  logic [19:0] exp_q [4];
  logic [19:0] t;
  logic [1:0] cs;
  int errors = 0, cmp_count = 0;
  sram_timing_readback i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mem_clk_en_o(mem_clk_en_o),
    .mux_mode_o(mux_mode_o), .write_pulse_eff_o(write_pulse_eff_o),
    .page_enable_o(page_enable_o), .cs_timing_o(cs_timing_o));
  sram_far_model i_far (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .mem_clk_en_i(mem_clk_en_o), .mem_ticks_o(ticks));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] rand_timing();
    return {3'($urandom_range(7, 1)), 3'($urandom_range(7, 1)), 3'($urandom_range(7, 1)),
      3'($urandom_range(7, 1)), 4'($urandom_range(15, 3)), 4'($urandom_range(15, 2))};
  endfunction
  // the widened pulse wraps at code 7, as the field has no spare bit
  function automatic logic [31:0] eff_pulse(logic [2:0] wp, logic mux);
    return 32'(3'(wp + 3'(mux)));
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus_wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic read_check(string name, logic [3:0] a, logic [31:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 check(name, rdata_o, exp);
  endtask
  task automatic conclude();
    $display("errors %0d cmp_count %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'hCFD3D675));
    repeat (12) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      exp_q[i] = 20'h2B3CC;
      read_check("reset value", 4'(i), 32'h0002B3CC);
    end
    #1 t0 = ticks;
    repeat (20) @(posedge sys_clk_i);
    #1 check("memory ticks", 32'(ticks - t0), 32'hA);
    // the first two passes hold every field at its top and bottom code
    for (int n = 0; n < 24; n++) begin
      t = (n == 0) ? 20'hFFFFF : (n == 1) ? 20'h24932 : rand_timing();
      cs = 2'($urandom_range(3, 0));
      bus_wr(4'h4, {12'h000, t});
      bus_wr(4'h5, {29'h0, cs, 1'b1});
      bus_wr(4'(cs), 32'hFFFFFFFF);
      exp_q[cs] = t;
      #1;
      for (int k = 0; k < 4; k++) begin
        check("timing out", 32'(cs_timing_o[k]), {12'h000, exp_q[k]});
        read_check("readback", 4'(k), {12'h000, exp_q[k]});
      end
    end
    bus_wr(4'h4, 32'h0002B3CC);
    for (int k = 0; k < 4; k++) bus_wr(4'h5, {29'h0, 2'(k), 1'b1});
    for (int m = 1; m >= 0; m--) begin
      bus_wr(4'h6, 32'(m));
      #1 check("write pulse", 32'(write_pulse_eff_o), eff_pulse(3'h6, m[0]));
      check("page enable", 32'(page_enable_o), 32'(!m[0]));
      check("mux mode", 32'(mux_mode_o), 32'(m[0]));
      read_check("mode", 4'h6, 32'(m));
    end
    read_check("unmapped", 4'hF, 32'h0);
    conclude();
  end
endmodule
